// >>> logic/counter_gate_time_base.sv
`timescale 1ns/100ps
// Notes on behaviour
// - the gate window timing comes from a 1 MHz reference derived from the clock; pulse widths and delays count clock cycles.
// - four decade dividers follow the reference; two run freely, the last two are preset each cycle.
// - the per-cycle reset loads the last divider with 9 and the third with 0.
// - gated divider advance is held off until a delay after the reset pulse has ended.
// - the start gate passes divider pulses only while the cycle flip-flop marks a cycle in progress.
// - the third divider's first pulse rolls the last from 9 to 0, which opens the 10 ms gate.
// - in sweep mode a positive initiate pulse from outside resets the cycle flip-flop.
// - resetting the cycle flip-flop fires the reset one-shot and begins a new cycle.
// - in counter mode the flip-flop is set at gate close and reset after an internal delay.
// - the set of the flip-flop at gate close fires the transfer pulse.
// - with no count in progress the gate stays off and the block output stays high.
// - the reset pulse clears the gate, presets the gated dividers, delays start and clears the counters.
// - at count end a short transfer pulse latches the counters into the display stores.
// - the counter-mode delay gives about five cycles each second.
// - while the gate is on each input pulse goes out as a count pulse.
module counter_gate_time_base #(
  parameter int REF_CYCLES        = time_base_pkg::REF_CYCLES,
  parameter int INIT_DELAY_CYCLES = time_base_pkg::INIT_DELAY_CYCLES
) (
  input  wire logic clk,                      // 40 MHz clock
  input  wire logic rst,                      // sync reset, high
  input  wire logic sweep_mode_select_line_n, // low selects scope/recorder
  input  wire logic counter_mode_select_line_n, // low selects counter
  input  wire logic count_initiate,           // comparator pulse, high
  input  wire logic input_pulse,              // conditioned input event
  output logic      gate_open_q,              // main gate true output
  output logic      gate_block_q,             // main gate complement
  output logic      count_pulse_q,            // count pulse to decades
  output logic      decade_clear_q,           // clear to decades, high
  output logic      transfer_q,               // latch into display stores
  output logic      cycle_idle_q              // sample-rate flip-flop true
);
  localparam int RW = 8;
  localparam int WIN_CYCLES = REF_CYCLES * time_base_pkg::REF_TICKS_PER_WINDOW;

  // reference prescaler
  logic [RW-1:0] ref_cnt_q, ref_cnt_d;
  logic          ref_tick;

  assign ref_tick = (ref_cnt_q == RW'(REF_CYCLES - 1));

  always_comb begin
    ref_cnt_d = ref_tick ? '0 : ref_cnt_q + RW'(1);
  end

  always_ff @(posedge clk) begin
    if (rst)
      ref_cnt_q <= '0;
    else
      ref_cnt_q <= ref_cnt_d;
  end

  // divider chain
  logic [3:0] first_digit, second_digit, third_digit, last_digit;
  logic       first_carry, second_carry, third_carry, last_carry;
  logic       reset_pulse, start_gate, third_adv;

  assign third_adv = second_carry && start_gate;

  decade_divider first_free_decade (
    .clk        (clk),
    .rst        (rst),
    .preset     (1'b0),
    .preset_val (time_base_pkg::DIGIT_ZERO),
    .adv        (ref_tick),
    .digit_q    (first_digit),
    .carry      (first_carry)
  );

  decade_divider second_free_decade (
    .clk        (clk),
    .rst        (rst),
    .preset     (1'b0),
    .preset_val (time_base_pkg::DIGIT_ZERO),
    .adv        (first_carry),
    .digit_q    (second_digit),
    .carry      (second_carry)
  );

  decade_divider third_gated_decade (
    .clk        (clk),
    .rst        (rst),
    .preset     (reset_pulse),
    .preset_val (time_base_pkg::THIRD_PRESET),
    .adv        (third_adv),
    .digit_q    (third_digit),
    .carry      (third_carry)
  );

  decade_divider last_gated_decade (
    .clk        (clk),
    .rst        (rst),
    .preset     (reset_pulse),
    .preset_val (time_base_pkg::LAST_PRESET),
    .adv        (third_carry),
    .digit_q    (last_digit),
    .carry      (last_carry)
  );

  // one-shots
  logic idle_prev_q;
  logic reset_trig, transfer_trig;

  assign reset_trig    = idle_prev_q && !cycle_idle_q;
  assign transfer_trig = !idle_prev_q && cycle_idle_q;

  pulse_one_shot #(.WIDTH(time_base_pkg::RESET_PULSE_CYCLES)) reset_one_shot (
    .clk     (clk),
    .rst     (rst),
    .trig    (reset_trig),
    .pulse_q (reset_pulse)
  );

  pulse_one_shot #(.WIDTH(time_base_pkg::TRANSFER_PULSE_CYCLES)) transfer_one_shot (
    .clk     (clk),
    .rst     (rst),
    .trig    (transfer_trig),
    .pulse_q (transfer_q)
  );

  assign decade_clear_q = reset_pulse;

  // start delay: trailing edge of reset delayed before the gated dividers may run
  logic [RW-1:0] start_cnt_q, start_cnt_d;
  logic          start_ok_q, start_ok_d;

  always_comb begin
    start_cnt_d = start_cnt_q;
    start_ok_d  = start_ok_q;
    // idle clears it too, so a new cycle never inherits the last one's finished delay
    if (reset_pulse || cycle_idle_q) begin
      start_cnt_d = '0;
      start_ok_d  = 1'b0;
    end else if (!start_ok_q) begin
      start_cnt_d = start_cnt_q + RW'(1);
      start_ok_d  = (start_cnt_q == RW'(time_base_pkg::START_DELAY_CYCLES - 1));
    end
  end

  assign start_gate = start_ok_q && !cycle_idle_q && !reset_pulse;

  always_ff @(posedge clk) begin
    if (rst) begin
      start_cnt_q <= '0;
      start_ok_q  <= 1'b0;
    end else begin
      start_cnt_q <= start_cnt_d;
      start_ok_q  <= start_ok_d;
    end
  end

  // main gate flip-flop
  logic gate_d;

  always_comb begin
    gate_d = gate_open_q;
    if (reset_pulse)
      gate_d = 1'b0;
    else if (last_carry)
      gate_d = !gate_open_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_open_q   <= 1'b0;
      gate_block_q  <= 1'b1;
      count_pulse_q <= 1'b0;
    end else begin
      gate_open_q   <= gate_d;
      gate_block_q  <= !gate_d;
      count_pulse_q <= input_pulse && gate_open_q;
    end
  end

  // sample-rate flip-flop and counter-mode initiate delay
  localparam int DELAY_W = time_base_pkg::DELAY_W;
  logic               sweep_sel, counter_sel, gate_closing;
  logic               init_prev_q, init_rise;
  logic               idle_d, delay_done;
  logic [DELAY_W-1:0] delay_cnt_q, delay_cnt_d;

  // sweep line wins if both are low; selection is the outside's duty
  assign sweep_sel    = !sweep_mode_select_line_n;
  assign counter_sel  = sweep_mode_select_line_n && !counter_mode_select_line_n;
  assign gate_closing = gate_open_q && last_carry && !reset_pulse;
  assign init_rise    = count_initiate && !init_prev_q;
  assign delay_done   = (delay_cnt_q == DELAY_W'(INIT_DELAY_CYCLES - 1));

  always_comb begin
    delay_cnt_d = '0;
    if (cycle_idle_q && counter_sel && !delay_done)
      delay_cnt_d = delay_cnt_q + DELAY_W'(1);
  end

  // gate close sets the flip-flop and wins over any initiate in that cycle
  always_comb begin
    idle_d = cycle_idle_q;
    if (gate_closing)
      idle_d = 1'b1;
    else if (sweep_sel && init_rise)
      idle_d = 1'b0;
    else if (counter_sel && cycle_idle_q && delay_done)
      idle_d = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cycle_idle_q <= 1'b1;
      idle_prev_q  <= 1'b1;
      init_prev_q  <= 1'b0;
      delay_cnt_q  <= '0;
    end else begin
      cycle_idle_q <= idle_d;
      idle_prev_q  <= cycle_idle_q;
      init_prev_q  <= count_initiate;
      delay_cnt_q  <= delay_cnt_d;
    end
  end

  // checker helpers
  logic [RW-1:0] ref_gap_q;
  logic [RW-1:0] clear_gap_q;
  logic [31:0]   win_cnt_q;
  logic          ref_seen_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_gap_q   <= '0;
      clear_gap_q <= '0;
      ref_seen_q  <= 1'b0;
      win_cnt_q   <= '0;
    end else begin
      ref_gap_q   <= ref_tick ? '0 : ref_gap_q + RW'(1);
      clear_gap_q <= reset_pulse ? '0 : ((&clear_gap_q) ? clear_gap_q : clear_gap_q + RW'(1));
      ref_seen_q <= ref_seen_q || ref_tick;
      win_cnt_q  <= gate_open_q ? win_cnt_q + 32'h1 : 32'h0;
    end
  end

  property p_ref_period;
    @(posedge clk) disable iff (rst)
      ref_tick && ref_seen_q |-> ref_gap_q == RW'(REF_CYCLES - 1);
  endproperty
  a_ref_period: assert property (p_ref_period) else $error("reference tick spacing wrong");

  property p_free_run;
    @(posedge clk) disable iff (rst)
      first_carry |=> second_digit != $past(second_digit);
  endproperty
  a_free_run: assert property (p_free_run) else $error("free divider did not advance");

  property p_preset;
    @(posedge clk) disable iff (rst)
      reset_pulse |=> last_digit == time_base_pkg::LAST_PRESET && third_digit == time_base_pkg::THIRD_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("gated dividers not preset");

  property p_start_hold;
    @(posedge clk) disable iff (rst)
      third_adv |-> clear_gap_q >= RW'(time_base_pkg::START_DELAY_CYCLES);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("dividers ran right after reset");

  property p_start_gate;
    @(posedge clk) disable iff (rst)
      cycle_idle_q |=> $stable(third_digit) && $stable(last_digit);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("divider pulse passed while idle");

  property p_gate_open;
    @(posedge clk) disable iff (rst)
      $rose(gate_open_q) |-> $past(last_carry) && last_digit == time_base_pkg::DIGIT_ZERO;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gate opened without rollover");

  property p_sweep_start;
    @(posedge clk) disable iff (rst)
      sweep_sel && init_rise && cycle_idle_q && !gate_closing |=> !cycle_idle_q ##1 decade_clear_q;
  endproperty
  a_sweep_start: assert property (p_sweep_start) else $error("initiate did not start a cycle");

  property p_counter_start;
    @(posedge clk) disable iff (rst)
      counter_sel && cycle_idle_q && delay_done && !gate_closing |=> !cycle_idle_q;
  endproperty
  a_counter_start: assert property (p_counter_start) else $error("internal delay did not start");

  property p_transfer;
    @(posedge clk) disable iff (rst)
      $rose(cycle_idle_q) |=> transfer_q;
  endproperty
  a_transfer: assert property (p_transfer) else $error("no transfer at count end");

  property p_idle_blocked;
    @(posedge clk) disable iff (rst)
      cycle_idle_q && !$past(gate_open_q) |-> gate_block_q && !count_pulse_q;
  endproperty
  a_idle_blocked: assert property (p_idle_blocked) else $error("input passed while idle");

  property p_clear_gate;
    @(posedge clk) disable iff (rst)
      decade_clear_q |=> !gate_open_q;
  endproperty
  a_clear_gate: assert property (p_clear_gate) else $error("reset did not clear gate");

  property p_count_pass;
    @(posedge clk) disable iff (rst)
      input_pulse && gate_open_q |=> count_pulse_q;
  endproperty
  a_count_pass: assert property (p_count_pass) else $error("count pulse lost");

  property p_window;
    @(posedge clk) disable iff (rst)
      $fell(gate_open_q) && !$past(reset_pulse) |-> $past(win_cnt_q) == 32'(WIN_CYCLES - 1);
  endproperty
  a_window: assert property (p_window) else $error("window length wrong");

endmodule

// >>> logic/time_base_pkg.sv
package time_base_pkg;

  localparam int CLK_MHZ = 40;
  localparam int CLK_HZ  = CLK_MHZ * 1_000_000;
  localparam int REF_HZ  = 1_000_000;
  localparam int REF_CYCLES = CLK_HZ / REF_HZ;

  localparam logic [3:0] DIGIT_ZERO   = 4'h0;
  localparam logic [3:0] DIGIT_MAX    = 4'h9;
  localparam logic [3:0] LAST_PRESET  = 4'h9;
  localparam logic [3:0] THIRD_PRESET = 4'h0;

  localparam int WINDOW_MS = 10;
  localparam int REF_TICKS_PER_WINDOW = WINDOW_MS * (REF_HZ / 1000);

  localparam int RESET_PULSE_NS    = 500;
  localparam int TRANSFER_PULSE_NS = 500;
  localparam int START_DELAY_NS    = 1000;

  localparam int COUNT_RATE_HZ = 5;
  localparam int REPEAT_MS     = 1000 / COUNT_RATE_HZ;
  localparam int INIT_DELAY_MS = REPEAT_MS - WINDOW_MS;
  localparam int INIT_DELAY_CYCLES = INIT_DELAY_MS * (CLK_HZ / 1000);
  localparam int DELAY_W = 24;

  // least times: round up, never below one cycle
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RESET_PULSE_CYCLES    = ns_to_cycles(RESET_PULSE_NS);
  localparam int TRANSFER_PULSE_CYCLES = ns_to_cycles(TRANSFER_PULSE_NS);
  localparam int START_DELAY_CYCLES    = ns_to_cycles(START_DELAY_NS);
  localparam int PULSE_W = 8;

endpackage

// >>> logic/decade_divider.sv
`timescale 1ns/100ps
module decade_divider (
  input  wire logic       clk,       // system clock
  input  wire logic       rst,       // sync reset, high
  input  wire logic       preset,    // load preset_val
  input  wire logic [3:0] preset_val,// value to load
  input  wire logic       adv,       // count one step
  output logic      [3:0] digit_q,   // current digit
  output logic            carry      // 9 to 0 rollover this cycle
);
  logic [3:0] digit_d;

  assign carry = adv && !preset && (digit_q == time_base_pkg::DIGIT_MAX);

  always_comb begin
    digit_d = digit_q;
    if (preset)
      digit_d = preset_val;
    else if (carry)
      digit_d = time_base_pkg::DIGIT_ZERO;
    else if (adv)
      digit_d = digit_q + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (rst)
      digit_q <= time_base_pkg::DIGIT_ZERO;
    else
      digit_q <= digit_d;
  end
endmodule

// >>> logic/pulse_one_shot.sv
`timescale 1ns/100ps
module pulse_one_shot #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // sync reset, high
  input  wire logic trig,    // start pulse
  output logic      pulse_q  // high for WIDTH cycles
);
  localparam int W = time_base_pkg::PULSE_W;
  logic [W-1:0] cnt_q, cnt_d;
  logic         pulse_d;

  // retrigger while running is ignored, like the analog one-shot
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q != '0)
      cnt_d = cnt_q - W'(1);
    else if (trig)
      cnt_d = W'(WIDTH);
    pulse_d = (cnt_d != '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end
endmodule

// >>> sim/sweep_counter_board_model.sv
`timescale 1ns/100ps
// stands for the sweep comparator and the decade counter board
module sweep_counter_board_model (
  input  wire logic        clk,            // system clock
  input  wire logic        fire,           // bench asks for one initiate
  output logic             count_initiate, // comparator pulse, high
  input  wire logic        count_pulse_q,  // count pulses from the gate
  input  wire logic        decade_clear_q, // clear for the decades
  input  wire logic        transfer_q,     // latch into display stores
  output logic      [15:0] display_q       // latched count
);
  logic        fire_q;
  logic        fire_seen;
  logic [15:0] decades;
  logic        transfer_prev;

  initial begin
    count_initiate = 1'b0;
    fire_q         = 1'b0;
    fire_seen      = 1'b0;
    decades        = 16'h0000;
    display_q      = 16'h0000;
    transfer_prev  = 1'b0;
  end

  // fire taken on the rising edge; the bench moves it on the falling one
  always @(posedge clk) begin
    fire_q <= fire;
  end

  // three-cycle positive pulse, launched off the sampling edge
  always @(negedge clk) begin
    fire_seen <= fire_q;
    if (fire_q && !fire_seen) begin
      count_initiate <= 1'b1;
      repeat (3) @(negedge clk);
      count_initiate <= 1'b0;
    end
  end

  always @(posedge clk) begin
    transfer_prev <= transfer_q;
    if (decade_clear_q === 1'b1) begin
      decades <= 16'h0000;
    end else if (count_pulse_q === 1'b1) begin
      decades <= decades + 16'h0001;
    end
    if (transfer_q === 1'b1 && transfer_prev !== 1'b1) begin
      display_q <= decades;
    end
  end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int REF   = 2;
  localparam int INIT  = 50;
  localparam int WIN   = time_base_pkg::REF_TICKS_PER_WINDOW * REF;
  localparam int PW    = time_base_pkg::RESET_PULSE_CYCLES;
  localparam int START = time_base_pkg::START_DELAY_CYCLES;

  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic        sweep_n     = 1'b1;
  logic        counter_n   = 1'b1;
  logic        input_pulse = 1'b0;
  logic        fire        = 1'b0;
  logic        count_initiate;
  logic        gate_open_q;
  logic        gate_block_q;
  logic        count_pulse_q;
  logic        decade_clear_q;
  logic        transfer_q;
  logic        cycle_idle_q;
  logic [15:0] display_q;
  int          errors      = 0;
  int          comparisons = 0;
  int          pulses      = 0;

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (count_pulse_q === 1'b1) pulses <= pulses + 1;
  end

  counter_gate_time_base #(.REF_CYCLES(REF), .INIT_DELAY_CYCLES(INIT)) u_counter_gate_time_base (
    .clk                        (clk),
    .rst                        (rst),
    .sweep_mode_select_line_n   (sweep_n),
    .counter_mode_select_line_n (counter_n),
    .count_initiate             (count_initiate),
    .input_pulse                (input_pulse),
    .gate_open_q                (gate_open_q),
    .gate_block_q               (gate_block_q),
    .count_pulse_q              (count_pulse_q),
    .decade_clear_q             (decade_clear_q),
    .transfer_q                 (transfer_q),
    .cycle_idle_q               (cycle_idle_q)
  );

  sweep_counter_board_model u_sweep_counter_board_model (
    .clk            (clk),
    .fire           (fire),
    .count_initiate (count_initiate),
    .count_pulse_q  (count_pulse_q),
    .decade_clear_q (decade_clear_q),
    .transfer_q     (transfer_q),
    .display_q      (display_q)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return cycle_idle_q;
      1: return decade_clear_q;
      2: return gate_open_q;
      default: return transfer_q;
    endcase
  endfunction

  // bounded wait, so a stuck output ends as a mismatch instead of a hang
  task automatic wait_sig(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check($sformatf("wait_on_%0d", w), {31'h0, sig(w)}, {31'h0, v});
  endtask

  task automatic width(input int w, input int lim, output int n);
    n = 0;
    while (sig(w) === 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic pulse_input;
    input_pulse = 1'b1;
    @(negedge clk);
    input_pulse = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset;
    check("gate_open", gate_open_q, 0);
    check("gate_block", gate_block_q, 1);
    check("idle", cycle_idle_q, 1);
    check("clear", decade_clear_q, 0);
    check("transfer", transfer_q, 0);
    $display("test reset done");
  endtask

  task automatic t_sweep;
    int n;
    int k;
    sweep_n = 1'b0;
    pulse_input();
    check("pulse_while_closed", pulses, 0);
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    wait_sig(0, 1'b0, 6, n);
    wait_sig(1, 1'b1, 3, n);
    width(1, 100, n);
    check("clear_width", n, PW);
    check("gate_after_clear", gate_open_q, 0);
    wait_sig(2, 1'b1, START + 2100, n);
    check("start_hold", n >= START, 1);
    check("gate_block_open", gate_block_q, 0);
    n = 0;
    k = 0;
    while (gate_open_q === 1'b1 && n < WIN + 10) begin
      input_pulse = (n >= 100 && n < 114 && n % 2 == 0);
      fire = (n == 300);
      @(negedge clk);
      n++;
      if (decade_clear_q === 1'b1) k++;
    end
    input_pulse = 1'b0;
    fire = 1'b0;
    check("window", n, WIN);
    check("clear_during_count", k, 0);
    check("pulses", pulses, 7);
    wait_sig(0, 1'b1, 3, n);
    wait_sig(3, 1'b1, 3, n);
    width(3, 100, n);
    check("transfer_width", n, time_base_pkg::TRANSFER_PULSE_CYCLES);
    check("latched", display_q, 7);
    check("gate_block_closed", gate_block_q, 1);
    k = 0;
    repeat (100) begin
      @(negedge clk);
      if (decade_clear_q === 1'b1) k++;
    end
    check("no_self_start", k, 0);
    pulse_input();
    check("pulse_after_close", pulses, 7);
    $display("test sweep done");
  endtask

  task automatic t_counter;
    int n;
    sweep_n = 1'b1;
    counter_n = 1'b0;
    wait_sig(0, 1'b0, INIT + 10, n);
    wait_sig(2, 1'b1, START + 2200, n);
    width(2, WIN + 10, n);
    check("window_counter", n, WIN);
    wait_sig(0, 1'b1, 3, n);
    width(0, INIT + 10, n);
    check("idle_span", n >= INIT && n <= INIT + 3, 1);
    check("cleared_count", display_q, 0);
    wait_sig(1, 1'b1, 3, n);
    width(1, 100, n);
    check("clear_width_counter", n, PW);
    repeat (50) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("gate_mid_reset", gate_open_q, 0);
    check("idle_mid_reset", cycle_idle_q, 1);
    rst = 1'b0;
    counter_n = 1'b1;
    repeat (3 * INIT) @(negedge clk);
    check("no_mode_idle", cycle_idle_q, 1);
    $display("test counter done");
  endtask

  task automatic summarize;
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // two full windows plus delays need about 45000 cycles
  initial begin
    repeat (90000) @(negedge clk);
    errors++;
    $display("unexpected watchdog: expected done, seen running");
    summarize();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_sweep();
    t_counter();
    summarize();
  end
endmodule
